// >>> include/thermal_pkg.sv
package thermal_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register bus
    localparam int         ADDR_W        = 8;
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_IRQ_ST    = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h0C;
    localparam logic [7:0] OFF_RATED     = 8'h10;
    localparam logic [7:0] OFF_BASE_FREQ = 8'h14;
    localparam logic [7:0] OFF_LEVEL     = 8'h18;
    localparam logic [7:0] OFF_CURVE     = 8'h24;
    localparam logic [7:0] OFF_BP_FREQ   = 8'h30;
    localparam logic [7:0] OFF_BP_CUR    = 8'h3C;
    localparam logic [7:0] OFF_WARN_THR  = 8'h48;
    localparam logic [7:0] OFF_OUT_SEL   = 8'h4C;
    localparam logic [7:0] OFF_ACC       = 8'h64;
    localparam logic [7:0] OFF_LIMIT     = 8'h68;
    localparam logic [7:0] OFF_LAST      = 8'h68;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // Field positions
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_CLR_BIT  = 1;
    localparam int IRQ_WARN_BIT  = 0;
    localparam int IRQ_TRIP_BIT  = 1;
    localparam int ST_TRIP_BIT   = 0;
    localparam int ST_WARN_BIT   = 1;
    localparam int ST_OFF_BIT    = 2;
    localparam int ST_CURVE_LSB  = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset (currents in 0.1 A, frequencies in 0.1 Hz)
    localparam logic        CTRL_EN_RST   = 1'b1;
    localparam logic [15:0] RATED_RST     = 16'h0186;
    localparam logic [15:0] BASE_FREQ_RST = 16'h0258;
    localparam logic [15:0] LEVEL_RST     = 16'h0186;
    localparam logic [1:0]  CURVE_RST     = 2'h1;
    localparam logic [15:0] BP_FREQ_RST   = 16'h0000;
    localparam logic [15:0] BP_CUR_RST    = 16'h0000;
    localparam logic [6:0]  WARN_THR_RST  = 7'h50;
    localparam logic [7:0]  OUT_SEL_RST   = 8'h00;

    // Setting limits and codes
    localparam logic [15:0] BP_FREQ_MAX       = 16'h0FA0;
    localparam logic [6:0]  WARN_THR_MAX      = 7'h64;
    localparam logic [15:0] LEVEL_MIN_DIV     = 16'h0005;
    localparam logic [7:0]  FUNC_THERMAL_WARN = 8'h0D;
    localparam logic [7:0]  TRIP_CODE         = 8'h05;
    localparam int          NUM_MOTORS        = 3;
    localparam int          NUM_BP            = 3;
    localparam int          NUM_OUTS          = 6;

    // Derating factors, 256 = full current
    localparam logic [8:0]  FACTOR_FULL  = 9'h100;
    localparam logic [8:0]  FACTOR_MID   = 9'h0E6;
    localparam logic [8:0]  FACTOR_LOW   = 9'h0CD;
    localparam logic [15:0] CT_KNEE_FREQ = 16'h0032;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          CTRL_CYCLE_NS = 100000;
    localparam int          TICK_CYCLES   = CTRL_CYCLE_NS / CLK_PERIOD_NS;
    localparam int          TICK_W        = 10;
    localparam logic [9:0]  TICK_LAST     = 10'(TICK_CYCLES - 1);
    // Kept small enough that a full trip fits a short test run
    localparam logic [31:0] ACC_TRIP      = 32'h003D_0900;
    localparam logic [39:0] PCT_FULL      = 40'h00_0000_0064;

    typedef enum logic [1:0] {
        CURVE_REDUCED,
        CURVE_CONSTANT,
        CURVE_FREE
    } curve_e;

endpackage

// >>> rtl/thermal_derate.sv
`timescale 1ns/10ps
module thermal_derate
    import thermal_pkg::*;
(
    input  wire logic [15:0] out_freq,
    input  wire logic [15:0] base_freq,
    input  wire logic [1:0]  curve,
    input  wire logic [15:0] level_eff,
    input  wire logic [15:0] breakpoint_freq_1,
    input  wire logic [15:0] breakpoint_freq_2,
    input  wire logic [15:0] breakpoint_freq_3,
    input  wire logic [15:0] breakpoint_current_1,
    input  wire logic [15:0] breakpoint_current_2,
    input  wire logic [15:0] breakpoint_current_3,
    output logic      [15:0] limit,
    output logic             prot_off
);

    logic [8:0]  factor;
    logic [24:0] prod;
    logic [15:0] bp_cur;

    always_comb
    begin
        factor   = FACTOR_FULL;
        prot_off = 1'b0;
        bp_cur   = breakpoint_current_3;
        prod     = 25'(level_eff) * 25'(factor);
        limit    = prod[23:8];
        case (curve_e'(curve))
            CURVE_REDUCED:
            begin
                // Cooling falls off below base speed
                if (out_freq >= base_freq)
                    factor = FACTOR_FULL;
                else if ({out_freq, 1'b0} >= {1'b0, base_freq})
                    factor = FACTOR_MID;
                else
                    factor = FACTOR_LOW;
                prod  = 25'(level_eff) * 25'(factor);
                limit = prod[23:8];
            end
            CURVE_FREE:
            begin
                // Step curve; no interpolation between breakpoints
                if (out_freq <= breakpoint_freq_1)
                    bp_cur = breakpoint_current_1;
                else if (out_freq <= breakpoint_freq_2)
                    bp_cur = breakpoint_current_2;
                else
                    bp_cur = breakpoint_current_3;
                limit = (bp_cur < level_eff) ? bp_cur : level_eff;
                prot_off = (breakpoint_current_1 == 16'h0000) ||
                           (breakpoint_current_2 == 16'h0000) ||
                           (breakpoint_current_3 == 16'h0000);
            end
            default:
            begin
                // Constant-torque, and the unused code 3
                factor = (out_freq >= CT_KNEE_FREQ) ? FACTOR_FULL : FACTOR_LOW;
                prod   = 25'(level_eff) * 25'(factor);
                limit  = prod[23:8];
            end
        endcase
    end

endmodule

// >>> rtl/motor_thermal_protection.sv
`timescale 1ns/10ps
// Behaviour
// - Trip when thermal accumulator reaches limit
// - Thermal level held within 0.2-1.0 rated
// - Three motor sets, active one applied
// - Curve codes: reduced, constant, free
// - Curve combined with level gives limit
// - Reduced-torque lowers limit at low speed
// - Three breakpoint frequencies, 0 to 400 Hz
// - Breakpoint currents up to rated current
// - Zero breakpoint current disables protection on the free curve
// - Warning asserts before or at trip
// - Warning threshold 1 to 100 percent
// - Zero threshold suppresses warning
// - Full threshold coincides with trip code
// - Warning on outputs selecting code 13
module motor_thermal_protection
    import thermal_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [15:0]       out_current,
    input  wire logic [15:0]       out_freq,
    input  wire logic [1:0]        motor_sel,
    output logic                   thermal_warning_output,
    output logic                   trip_out,
    output logic [7:0]             overload_trip_code,
    output logic [4:0]             term_out,
    output logic                   relay_out,
    output logic                   irq
);

    typedef struct packed {
        logic                             aw_full;
        logic [ADDR_W-1:0]                aw_addr;
        logic                             w_full;
        logic [31:0]                      w_data;
        logic [3:0]                       w_strb;
        logic                             bvalid;
        logic [1:0]                       bresp;
        logic                             rvalid;
        logic [31:0]                      rdata;
        logic [1:0]                       rresp;
        logic                             enable;
        logic [15:0]                      rated;
        logic [15:0]                      base_freq;
        logic [NUM_MOTORS-1:0][15:0]      level;
        logic [NUM_MOTORS-1:0][1:0]       curve;
        logic [NUM_BP-1:0][15:0]          bpf;
        logic [NUM_BP-1:0][15:0]          bpc;
        logic [6:0]                       warn_thr;
        logic [NUM_OUTS-1:0][7:0]         osel;
        logic [1:0]                       irq_st;
        logic [1:0]                       irq_mask;
        logic [TICK_W-1:0]                tick_cnt;
        logic [31:0]                      acc;
        logic                             trip;
        logic                             warn;
        logic [NUM_OUTS-1:0]              out_pins;
        logic [7:0]                       trip_code;
    } state_s;

    state_s      st_q;
    state_s      st_d;
    logic [1:0]  motor_idx;
    logic [15:0] level_raw;
    logic [15:0] level_min;
    logic [15:0] level_eff;
    logic [1:0]  curve_act;
    logic [15:0] limit;
    logic        prot_off;
    logic        tick;
    logic [31:0] status_w;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] strb_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                r[b*8 +: 8] = new_w[b*8 +: 8];
        return r;
    endfunction

    function automatic logic [7:0] slot(input logic [7:0] base, input int i);
        return base + 8'(i * 4);
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && (a <= OFF_LAST);
    endfunction

    function automatic logic [31:0] rd_word(input state_s s, input logic [7:0] a,
                                            input logic [31:0] stat,
                                            input logic [15:0] lim);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == OFF_CTRL)      r[CTRL_EN_BIT] = s.enable;
        if (a == OFF_STATUS)    r = stat;
        if (a == OFF_IRQ_ST)    r[1:0] = s.irq_st;
        if (a == OFF_IRQ_MASK)  r[1:0] = s.irq_mask;
        if (a == OFF_RATED)     r[15:0] = s.rated;
        if (a == OFF_BASE_FREQ) r[15:0] = s.base_freq;
        if (a == OFF_WARN_THR)  r[6:0] = s.warn_thr;
        if (a == OFF_ACC)       r = s.acc;
        if (a == OFF_LIMIT)     r[15:0] = lim;
        for (int i = 0; i < NUM_MOTORS; i++)
        begin
            if (a == slot(OFF_LEVEL, i)) r[15:0] = s.level[i];
            if (a == slot(OFF_CURVE, i)) r[1:0] = s.curve[i];
        end
        for (int i = 0; i < NUM_BP; i++)
        begin
            if (a == slot(OFF_BP_FREQ, i)) r[15:0] = s.bpf[i];
            if (a == slot(OFF_BP_CUR, i))  r[15:0] = s.bpc[i];
        end
        for (int i = 0; i < NUM_OUTS; i++)
            if (a == slot(OFF_OUT_SEL, i)) r[7:0] = s.osel[i];
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Active motor set and derating
    assign motor_idx = (motor_sel == 2'h3) ? 2'h0 : motor_sel;
    assign level_raw = st_q.level[motor_idx];
    assign curve_act = st_q.curve[motor_idx];
    assign level_min = st_q.rated / LEVEL_MIN_DIV;
    // Clamped at use so a later change of rated current still holds
    assign level_eff = (level_raw < level_min) ? level_min :
                       (level_raw > st_q.rated) ? st_q.rated : level_raw;
    assign tick      = (st_q.tick_cnt == TICK_LAST);

    thermal_derate u_derate (
        .out_freq             (out_freq),
        .base_freq            (st_q.base_freq),
        .curve                (curve_act),
        .level_eff            (level_eff),
        .breakpoint_freq_1    (st_q.bpf[0]),
        .breakpoint_freq_2    (st_q.bpf[1]),
        .breakpoint_freq_3    (st_q.bpf[2]),
        .breakpoint_current_1 (st_q.bpc[0]),
        .breakpoint_current_2 (st_q.bpc[1]),
        .breakpoint_current_3 (st_q.bpc[2]),
        .limit                (limit),
        .prot_off             (prot_off)
    );

    always_comb
    begin
        status_w = 32'h0000_0000;
        status_w[ST_TRIP_BIT] = st_q.trip;
        status_w[ST_WARN_BIT] = st_q.warn;
        status_w[ST_OFF_BIT]  = prot_off;
        status_w[ST_CURVE_LSB +: 2] = curve_act;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        logic        wr_go;
        logic        ctrl_clr;
        logic [1:0]  irq_clr;
        logic [1:0]  irq_set;
        logic [31:0] m;
        logic [32:0] sum;
        logic [15:0] diff;
        logic [6:0]  thr;
        logic [15:0] v16;
        wr_go    = st_q.aw_full && st_q.w_full && !st_q.bvalid;
        ctrl_clr = 1'b0;
        irq_clr  = 2'h0;
        irq_set  = 2'h0;
        m        = 32'h0000_0000;
        sum      = 33'h0_0000_0000;
        diff     = 16'h0000;
        thr      = 7'h00;
        v16      = 16'h0000;
        st_d     = st_q;

        // Write address and data taken independently
        if (s_axi_awvalid && !st_q.aw_full)
        begin
            st_d.aw_full = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_full)
        begin
            st_d.w_full = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        if (st_q.bvalid && s_axi_bready)
            st_d.bvalid = 1'b0;

        if (wr_go)
        begin
            st_d.aw_full = 1'b0;
            st_d.w_full  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = mapped(st_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            m   = strb_merge(rd_word(st_q, st_q.aw_addr, status_w, limit),
                             st_q.w_data, st_q.w_strb);
            v16 = m[15:0];
            if (st_q.aw_addr == OFF_CTRL)
            begin
                st_d.enable = m[CTRL_EN_BIT];
                ctrl_clr    = st_q.w_strb[0] && st_q.w_data[CTRL_CLR_BIT];
            end
            if (st_q.aw_addr == OFF_IRQ_ST && st_q.w_strb[0])
                irq_clr = st_q.w_data[1:0];
            if (st_q.aw_addr == OFF_IRQ_MASK)  st_d.irq_mask  = m[1:0];
            if (st_q.aw_addr == OFF_RATED)     st_d.rated     = v16;
            if (st_q.aw_addr == OFF_BASE_FREQ) st_d.base_freq = v16;
            if (st_q.aw_addr == OFF_WARN_THR)
            begin
                thr = m[6:0];
                st_d.warn_thr = (thr > WARN_THR_MAX) ? WARN_THR_MAX : thr;
            end
            for (int i = 0; i < NUM_MOTORS; i++)
            begin
                if (st_q.aw_addr == slot(OFF_LEVEL, i)) st_d.level[i] = v16;
                if (st_q.aw_addr == slot(OFF_CURVE, i)) st_d.curve[i] = m[1:0];
            end
            for (int i = 0; i < NUM_BP; i++)
            begin
                if (st_q.aw_addr == slot(OFF_BP_FREQ, i))
                    st_d.bpf[i] = (v16 > BP_FREQ_MAX) ? BP_FREQ_MAX : v16;
                if (st_q.aw_addr == slot(OFF_BP_CUR, i))
                    st_d.bpc[i] = (v16 > st_q.rated) ? st_q.rated : v16;
            end
            for (int i = 0; i < NUM_OUTS; i++)
                if (st_q.aw_addr == slot(OFF_OUT_SEL, i))
                    st_d.osel[i] = m[7:0];
        end

        // Read channel; one read in flight
        if (st_q.rvalid && s_axi_rready)
            st_d.rvalid = 1'b0;
        if (s_axi_arvalid && !st_q.rvalid)
        begin
            st_d.rvalid = 1'b1;
            st_d.rdata  = rd_word(st_q, s_axi_araddr, status_w, limit);
            st_d.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        // Control cycle
        st_d.tick_cnt = tick ? '0 : st_q.tick_cnt + 10'h001;
        // A trip set on a tick wins over a clear in the same cycle
        if (ctrl_clr)
        begin
            st_d.trip = 1'b0;
            st_d.acc  = 32'h0000_0000;
        end
        if (prot_off)
            st_d.acc = 32'h0000_0000;
        else if (tick && st_q.enable && !st_q.trip)
        begin
            // Linear heating and cooling stand in for the real curves
            if (out_current > limit)
            begin
                sum = {1'b0, st_q.acc} + 33'(out_current - limit);
                st_d.acc = (sum >= {1'b0, ACC_TRIP}) ? ACC_TRIP : sum[31:0];
            end
            else
            begin
                diff = limit - out_current;
                st_d.acc = (st_q.acc > 32'(diff)) ? st_q.acc - 32'(diff) : 32'h0000_0000;
            end
            if (st_d.acc >= ACC_TRIP)
                st_d.trip = 1'b1;
        end

        // Warning from the same value as the trip, so 100 % lands with it
        st_d.warn = (st_q.warn_thr != 7'h00) &&
                    (40'(st_d.acc) * PCT_FULL >= 40'(st_q.warn_thr) * 40'(ACC_TRIP));
        st_d.trip_code = st_d.trip ? TRIP_CODE : 8'h00;
        for (int i = 0; i < NUM_OUTS; i++)
            st_d.out_pins[i] = (st_q.osel[i] == FUNC_THERMAL_WARN) && st_d.warn;

        // Set wins over a clear in the same cycle
        irq_set[IRQ_WARN_BIT] = st_d.warn && !st_q.warn;
        irq_set[IRQ_TRIP_BIT] = st_d.trip && !st_q.trip;
        st_d.irq_st = (st_q.irq_st & ~irq_clr) | irq_set;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            st_q           <= '0;
            st_q.enable    <= CTRL_EN_RST;
            st_q.rated     <= RATED_RST;
            st_q.base_freq <= BASE_FREQ_RST;
            st_q.level     <= {NUM_MOTORS{LEVEL_RST}};
            st_q.curve     <= {NUM_MOTORS{CURVE_RST}};
            st_q.bpf       <= {NUM_BP{BP_FREQ_RST}};
            st_q.bpc       <= {NUM_BP{BP_CUR_RST}};
            st_q.warn_thr  <= WARN_THR_RST;
            st_q.osel      <= {NUM_OUTS{OUT_SEL_RST}};
        end
        else
            st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign s_axi_awready          = !st_q.aw_full;
    assign s_axi_wready           = !st_q.w_full;
    assign s_axi_bvalid           = st_q.bvalid;
    assign s_axi_bresp            = st_q.bresp;
    assign s_axi_arready          = !st_q.rvalid;
    assign s_axi_rvalid           = st_q.rvalid;
    assign s_axi_rdata            = st_q.rdata;
    assign s_axi_rresp            = st_q.rresp;
    assign thermal_warning_output = st_q.warn;
    assign trip_out               = st_q.trip;
    assign overload_trip_code     = st_q.trip_code;
    assign term_out               = st_q.out_pins[4:0];
    assign relay_out              = st_q.out_pins[5];
    assign irq                    = |(st_q.irq_st & st_q.irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_trip_at_limit: assert property ($rose(trip_out) |-> st_q.acc == ACC_TRIP)
        else $error("trip without full accumulator");
    a_level_in_range: assert property (level_eff >= level_min && level_eff <= st_q.rated)
        else $error("thermal level outside range");
    a_motor_set_used: assert property (motor_sel == 2'h2 |-> curve_act == st_q.curve[2])
        else $error("wrong motor set applied");
    a_free_below_level: assert property (curve_act == 2'h2 |-> limit <= level_eff)
        else $error("free limit above thermal level");
    a_reduced_derate: assert property (curve_act == 2'h0 && out_freq < st_q.base_freq
                                       && level_eff >= 16'h0008 |-> limit < level_eff)
        else $error("reduced curve not derated");
    a_zero_bp_off: assert property (prot_off |=> st_q.acc == 32'h0000_0000 && !$rose(trip_out))
        else $error("protection active with zero breakpoint");
    a_warn_with_trip: assert property ($rose(trip_out) && $past(st_q.warn_thr) != 7'h00
                                       |-> thermal_warning_output)
        else $error("trip without warning");
    a_warn_suppressed: assert property ($past(st_q.warn_thr) == 7'h00 |-> !thermal_warning_output)
        else $error("warning with zero threshold");
    a_trip_code: assert property (trip_out |-> overload_trip_code == TRIP_CODE)
        else $error("trip code missing");
    a_relay_follows: assert property (st_q.osel[5] == FUNC_THERMAL_WARN && $stable(st_q.osel[5])
                                      && thermal_warning_output |-> relay_out)
        else $error("relay not driven by warning");
    a_acc_decays: assert property (tick && st_q.enable && !st_q.trip && !prot_off
                                   && out_current < limit && st_q.acc != 32'h0000_0000
                                   && !st_d.trip |=> st_q.acc < $past(st_q.acc))
        else $error("accumulator did not decay");

endmodule

// >>> verif/motor_model.sv
`timescale 1ns/10ps
module motor_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] load,
    input  wire logic [15:0] speed,
    output logic      [15:0] out_current,
    output logic      [15:0] out_freq
);
    // Sensed values lag the load by one cycle, as a real sensor would
    always_ff @(posedge sys_clk)
    begin
        out_current <= load;
        out_freq    <= speed;
    end
endmodule

// >>> verif/motor_thermal_protection_tb.sv
`timescale 1ns/10ps
module motor_thermal_protection_tb;
    import thermal_pkg::*;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  motor_sel = 2'h0, s_axi_bresp, s_axi_rresp;
    logic [15:0] load = 16'h0, speed = 16'h0258, out_current, out_freq;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        thermal_warning_output, trip_out, relay_out, irq;
    logic [7:0]  overload_trip_code;
    logic [4:0]  term_out;
    int          errors = 0, cmp_count = 0, cyc = 0;
    motor_model i_motor_model (.sys_clk, .load, .speed, .out_current, .out_freq);
    motor_thermal_protection i_motor_thermal_protection (.sys_clk, .sys_rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .out_current, .out_freq, .motor_sel, .thermal_warning_output,
        .trip_out, .overload_trip_code, .term_out, .relay_out, .irq);
    always #50 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////
    task test_done;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Trip takes about 62 ticks of 1000 cycles, so the ceiling sits above that
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            errors++;
            test_done;
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            errors++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Ready lines stay high, so bready and rready never drop before an answer
    task wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        chk(32'(s_axi_bresp), (a > OFF_LAST) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY));
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
        forever
        begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(er));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_regs;
        rd(OFF_LEVEL, 32'(LEVEL_RST), RESP_OKAY);
        rd(OFF_CURVE, 32'(CURVE_RST), RESP_OKAY);
        rd(OFF_WARN_THR, 32'(WARN_THR_RST), RESP_OKAY);
        rd(8'h70, 32'h0, RESP_SLVERR);
        wr(8'h70, 32'h1);
        wr(OFF_BP_FREQ, 32'h0000_FFFF);
        rd(OFF_BP_FREQ, 32'(BP_FREQ_MAX), RESP_OKAY);
    endtask
    task t_curves;
        motor_sel <= 2'h1;
        wr(8'h1C, 32'h1);
        rd(OFF_LIMIT, 32'(RATED_RST / 5), RESP_OKAY);
        motor_sel <= 2'h2;
        wr(8'h20, 32'h0FFF);
        rd(OFF_LIMIT, 32'(RATED_RST), RESP_OKAY);
        motor_sel <= 2'h0; speed <= 16'h00C8;
        wr(OFF_CURVE, 32'h0);
        rd(OFF_LIMIT, (32'(RATED_RST) * 32'(FACTOR_LOW)) >> 8, RESP_OKAY);
        wr(OFF_CURVE, 32'h2);
        rd(OFF_STATUS, 32'h24, RESP_OKAY);
        for (int i = 0; i < 3; i++) wr(OFF_BP_CUR + 8'(4 * i), 32'h64);
        rd(OFF_LIMIT, 32'h64, RESP_OKAY);
        wr(OFF_CURVE, 32'h1); speed <= 16'h0258;
    endtask
    task t_warn_trip;
        wr(OFF_IRQ_MASK, 32'h3); wr(OFF_OUT_SEL, 32'(FUNC_THERMAL_WARN)); wr(OFF_WARN_THR, 32'h1);
        wr(OFF_OUT_SEL + 8'h14, 32'(FUNC_THERMAL_WARN));
        load <= 16'hFFFF;
        repeat (3000) @(posedge sys_clk);
        chk({thermal_warning_output, term_out, relay_out, irq}, 8'h87);
        wr(OFF_WARN_THR, 32'h0);
        repeat (2) @(posedge sys_clk);
        chk(thermal_warning_output, 1'b0);
        wr(OFF_WARN_THR, 32'h64);
        for (int i = 0; i < 80 && trip_out !== 1'b1; i++) repeat (1000) @(posedge sys_clk);
        chk({trip_out, overload_trip_code}, {1'b1, TRIP_CODE});
        load <= 16'h0;
        wr(OFF_CTRL, 32'h3); wr(OFF_IRQ_ST, 32'h3);
        repeat (2) @(posedge sys_clk);
        chk({trip_out, irq}, 2'b00);
    endtask
    initial
    begin
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs;
        t_curves;
        t_warn_trip;
        test_done;
    end
endmodule
